// >>> hdl/splitter_cfg.svh
// Register offsets, reset values and control bit positions of the
// splitter channel block. Included by splitter_channel_io by bare name.
`ifndef SPLITTER_CFG_SVH
`define SPLITTER_CFG_SVH
`define OFS_DIR 4'h0
`define OFS_PIN2_MODE 4'h1
`define OFS_IN_MASK 4'h2
`define OFS_FB_MODE 4'h3
`define OFS_FB_VALUE 4'h4
`define OFS_OUT_MASK 4'h5
`define OFS_OUT_CMD 4'h6
`define OFS_CTRL 4'h7
`define OFS_WORD0 4'h8
`define OFS_WORD5 4'hd
`define OFS_OUT_STATE 4'he
`define RST_DIR 8'h00
`define RST_PIN2_MODE 8'hff
`define RST_IN_MASK 8'h00
`define RST_FB_MODE 8'hff
`define RST_FB_VALUE 8'h00
`define RST_OUT_MASK 8'hff
`define CTRL_DOWNLOAD 0
`define CTRL_RESET 1
`define CTRL_STORE 2
`define CTRL_STOP 3
`define CTRL_RESUME 4
`endif

// >>> hdl/splitter_pkg.sv
// Types shared by the splitter channel block.
// Assumes splitter_cfg.svh holds the numeric constants.
package splitter_pkg;
  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_FALL = 3'b010,
    MODE_STOP = 3'b100
  } mode_e;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] p2mode;
    logic [7:0] inmask;
    logic [7:0] fbmode;
    logic [7:0] fbval;
    logic [7:0] omask;
    logic [7:0] cmd;
    logic fb_lat;
    logic stop_lat;
    mode_e mode;
    logic [15:0] rdata;
  } core_s;
endpackage

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s st_reg;
  sync_s st_next;
  // First stage feeds only the second stage
  always_comb begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_o = st_reg.s2;
endmodule // pin_sync

// >>> hdl/output_hold.sv
// Pin-4 output latches of the eight sockets with fallback and hold.
// Assumes fallback_i and hold_i are synchronous to ref_clk_i.
`timescale 1ns/1ps
module output_hold (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] omask_i,
  input wire logic [7:0] fbmode_i,
  input wire logic [7:0] fbval_i,
  input wire logic fallback_i,
  input wire logic hold_i,
  output logic [7:0] out_o
);
  logic [7:0] out_reg;
  logic [7:0] out_next;
  always_comb begin
    if (hold_i) begin
      // Stop freezes everything, fallback settings ignored
      out_next = out_reg;
    end else if (fallback_i) begin
      out_next = (fbmode_i & fbval_i) | (~fbmode_i & out_reg);
    end else begin
      out_next = (omask_i & cmd_i) | (~omask_i & out_reg);
    end
  end
  // Bits with mode 0 keep their value: bits with mode 1 load
  // the fallback value: masked-off bits keep theirs
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_reg <= 8'h00;
    end else begin
      out_reg <= out_next;
    end
  end
  assign out_o = out_reg;
endmodule // output_hold

// >>> hdl/splitter_channel_io.sv
// Eight-socket splitter channel logic: pin-4 direction, input and
// output masks, pin-2 diagnostics, fallback and hold-on-stop, and the
// six-word input image read over a plain register port.
// Assumes event inputs come from logic on ref_clk_i; pins are async.
//
// Functional notes
// - Direction bit 1 drives pin 4 as output
// - Direction bit 0 makes pin 4 an input
// - Pin 2 reports same-socket diagnostics by default
// - Input mask resets 0, input reported
// - Input mask 1 hides that channel input
// - Input mask also gates pin-2 diagnostics
// - Lost communication sends outputs to fallback state
// - Fallback mode resets 1, predefined value
// - Fallback mode 0 holds, value ignored
// - Hold-last-value keeps output while link lost
// - Fallback value single bit, resets to 0
// - Output mask resets 1, output follows command
// - Output mask 0 keeps last output value
// - Module, cable, download, reset, store trigger fallback
// - Online stop freezes outputs, ignores fallback settings
// - Six 16-bit words of inputs and diagnostics
// - Words contiguous, input data before diagnostics
// - Pin-2 mode 1 diagnostics, 0 extra sensor
// - Diagnostic bit 1 when pin 2 has no signal
`timescale 1ns/1ps
`include "splitter_cfg.svh"
module splitter_channel_io (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [15:0] rd_data_o,
  input wire logic comm_lost_i,
  input wire logic iface_fail_i,
  input wire logic bus_cable_lost_i,
  input wire logic ext_cable_lost_i,
  input wire logic [7:0] pin4_i,
  output logic [7:0] pin4_o,
  output logic [7:0] pin4_oe_n_o,
  input wire logic [7:0] pin2_i,
  input wire logic [15:0] common_diag_i,
  input wire logic [7:0] sensor_short_i,
  input wire logic [7:0] act_short_i,
  input wire logic [7:0] act_warn_i,
  output logic fallback_o,
  output logic stop_o
);
  splitter_pkg::core_s st_reg;
  splitter_pkg::core_s st_next;
  logic [55:0] pins_s;
  logic [7:0] p4_s;
  logic [7:0] p2_s;
  logic [15:0] cdiag_s;
  logic [7:0] sshort_s;
  logic [7:0] ashort_s;
  logic [7:0] awarn_s;
  logic [7:0] out_q;
  logic [7:0] p2_val;
  logic [15:0] word [6];
  logic wr_ctrl;
  logic link_loss;
  logic cmd_evt;
  logic fb_now;
  logic hold_now;

  function automatic logic [15:0] keep8(input logic [7:0] v,
                                        input logic [7:0] en);
    keep8 = {8'h00, v & en};
  endfunction

  pin_sync #(.W(56)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({pin4_i, pin2_i, common_diag_i, sensor_short_i, act_short_i,
          act_warn_i}),
    .q_o(pins_s)
  );
  assign p4_s = pins_s[55:48];
  assign p2_s = pins_s[47:40];
  assign cdiag_s = pins_s[39:24];
  assign sshort_s = pins_s[23:16];
  assign ashort_s = pins_s[15:8];
  assign awarn_s = pins_s[7:0];

  // Input image: word 0 pin-4 inputs, word 1 pin-2, then diagnostics
  // Output sockets and masked channels read as zero
  assign word[0] = keep8(p4_s, ~st_reg.dir & ~st_reg.inmask);
  // Diagnostic mode reports absence of signal, sensor mode the level
  assign p2_val = (st_reg.p2mode & ~p2_s) | (~st_reg.p2mode & p2_s);
  assign word[1] = keep8(p2_val, ~st_reg.inmask);
  assign word[2] = cdiag_s;
  // Sensor mode on pin 2 suppresses that socket's diagnostics
  assign word[3] = keep8(sshort_s, st_reg.p2mode);
  assign word[4] = keep8(ashort_s, st_reg.dir & st_reg.p2mode);
  assign word[5] = keep8(awarn_s, st_reg.dir & st_reg.p2mode);

  assign wr_ctrl = wr_en_i && addr_i == `OFS_CTRL;
  // Every loss event is one synchronous level into the output logic
  assign link_loss = comm_lost_i | iface_fail_i | bus_cable_lost_i
                   | ext_cable_lost_i;
  assign cmd_evt = wr_ctrl && (wr_data_i[`CTRL_DOWNLOAD]
                   || wr_data_i[`CTRL_RESET]
                   || wr_data_i[`CTRL_STORE]);
  // Combinational so outputs react at the first edge after the event
  assign fb_now = link_loss | cmd_evt | st_reg.fb_lat;
  // Stop outranks every loss event; a level loss still present at
  // resume takes effect then, a finished one leaves no trace
  assign hold_now = st_reg.stop_lat
                  | (wr_ctrl && wr_data_i[`CTRL_STOP]);

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    if (wr_en_i) begin
      unique case (addr_i)
        `OFS_DIR: st_next.dir = wr_data_i[7:0];
        `OFS_PIN2_MODE: st_next.p2mode = wr_data_i[7:0];
        `OFS_IN_MASK: st_next.inmask = wr_data_i[7:0];
        `OFS_FB_MODE: st_next.fbmode = wr_data_i[7:0];
        `OFS_FB_VALUE: st_next.fbval = wr_data_i[7:0];
        `OFS_OUT_MASK: st_next.omask = wr_data_i[7:0];
        `OFS_OUT_CMD: st_next.cmd = wr_data_i[7:0];
        default: st_next.cmd = st_reg.cmd;
      endcase
    end
    // Resume clears the latches, but a new event in the same cycle wins
    if (wr_ctrl && wr_data_i[`CTRL_RESUME]) begin
      st_next.fb_lat = 1'b0;
      st_next.stop_lat = 1'b0;
    end
    if (cmd_evt) begin
      st_next.fb_lat = 1'b1;
    end
    if (wr_ctrl && wr_data_i[`CTRL_STOP]) begin
      st_next.stop_lat = 1'b1;
    end
    if (hold_now) begin
      st_next.mode = splitter_pkg::MODE_STOP;
    end else if (fb_now) begin
      st_next.mode = splitter_pkg::MODE_FALL;
    end else begin
      st_next.mode = splitter_pkg::MODE_RUN;
    end
    if (rd_en_i) begin
      if (addr_i >= `OFS_WORD0 && addr_i <= `OFS_WORD5) begin
        st_next.rdata = word[3'(addr_i - `OFS_WORD0)];
      end else begin
        unique case (addr_i)
          `OFS_DIR: st_next.rdata = {8'h00, st_reg.dir};
          `OFS_PIN2_MODE: st_next.rdata = {8'h00, st_reg.p2mode};
          `OFS_IN_MASK: st_next.rdata = {8'h00, st_reg.inmask};
          `OFS_FB_MODE: st_next.rdata = {8'h00, st_reg.fbmode};
          `OFS_FB_VALUE: st_next.rdata = {8'h00, st_reg.fbval};
          `OFS_OUT_MASK: st_next.rdata = {8'h00, st_reg.omask};
          `OFS_OUT_CMD: st_next.rdata = {8'h00, st_reg.cmd};
          `OFS_CTRL: st_next.rdata = {13'h0000, st_reg.mode};
          `OFS_OUT_STATE: st_next.rdata = {8'h00, out_q};
          default: st_next.rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg.dir <= `RST_DIR;
      st_reg.p2mode <= `RST_PIN2_MODE;
      st_reg.inmask <= `RST_IN_MASK;
      st_reg.fbmode <= `RST_FB_MODE;
      st_reg.fbval <= `RST_FB_VALUE;
      st_reg.omask <= `RST_OUT_MASK;
      st_reg.cmd <= 8'h00;
      st_reg.fb_lat <= 1'b0;
      st_reg.stop_lat <= 1'b0;
      st_reg.mode <= splitter_pkg::MODE_RUN;
      st_reg.rdata <= 16'h0000;
    end else begin
      st_reg <= st_next;
    end
  end

  output_hold u_out (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cmd_i(st_reg.cmd),
    .omask_i(st_reg.omask),
    .fbmode_i(st_reg.fbmode),
    .fbval_i(st_reg.fbval),
    .fallback_i(fb_now),
    .hold_i(hold_now),
    .out_o(out_q)
  );

  // Input sockets see a released pin; value bit stays low there too
  assign pin4_o = out_q & st_reg.dir;
  assign pin4_oe_n_o = ~st_reg.dir;
  assign rd_data_o = st_reg.rdata;
  assign fallback_o = st_reg.mode == splitter_pkg::MODE_FALL;
  assign stop_o = st_reg.mode == splitter_pkg::MODE_STOP;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  dir_drive_a: assert property (
    wr_en_i && addr_i == `OFS_DIR |=>
      pin4_oe_n_o == ~$past(wr_data_i[7:0]) ##1
      pin4_oe_n_o == ~st_reg.dir)
    else $error("pin-4 enable does not follow direction write");

  in_dir_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 |=>
      (rd_data_o[7:0] & $past(st_reg.dir)) == 8'h00)
    else $error("output socket reported as input");

  in_mask_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 |=>
      (rd_data_o[7:0] & $past(st_reg.inmask)) == 8'h00
      && rd_data_o[15:8] == 8'h00)
    else $error("masked input reported");

  in_report_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 |=>
      rd_data_o[7:0] == ($past(p4_s) & ~$past(st_reg.dir)
                         & ~$past(st_reg.inmask)))
    else $error("unmasked input not reported");

  diag_level_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 + 4'h1 |=>
      rd_data_o[7:0] == (~$past(st_reg.inmask) &
        ($past(st_reg.p2mode) ^ $past(p2_s))))
    else $error("pin-2 word wrong");

  diag_suppress_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 + 4'h4 |=>
      (rd_data_o[7:0] & ~$past(st_reg.p2mode)) == 8'h00)
    else $error("diagnostics not suppressed in sensor mode");

  fb_value_a: assert property (
    fb_now && !hold_now |=>
      ((out_q ^ $past(st_reg.fbval)) & $past(st_reg.fbmode)) == 8'h00)
    else $error("predefined fallback value not applied");

  fb_hold_a: assert property (
    fb_now && !hold_now |=>
      ((out_q ^ $past(out_q)) & ~$past(st_reg.fbmode)) == 8'h00)
    else $error("hold-last-value output changed");

  link_fall_a: assert property (
    $rose(comm_lost_i) && !hold_now |=> fallback_o ##0
      ((out_q ^ $past(st_reg.fbval)) & $past(st_reg.fbmode)) == 8'h00)
    else $error("fallback not applied one cycle after loss");

  cmd_fall_a: assert property (
    cmd_evt && !hold_now |=> fallback_o [*2])
    else $error("command event did not latch fallback");

  stop_freeze_a: assert property (
    hold_now |=> $stable(out_q) && stop_o)
    else $error("outputs moved during stop");

  out_follow_a: assert property (
    !fb_now && !hold_now |=>
      ((out_q ^ $past(st_reg.cmd)) & $past(st_reg.omask)) == 8'h00)
    else $error("unmasked output does not follow command");

  out_keep_a: assert property (
    !fb_now && !hold_now |=>
      ((out_q ^ $past(out_q)) & ~$past(st_reg.omask)) == 8'h00)
    else $error("masked output changed");

  reset_vals_a: assert property (disable iff (1'b0)
    rst_i |=> st_reg.fbmode == `RST_FB_MODE
      && st_reg.omask == `RST_OUT_MASK && st_reg.inmask == `RST_IN_MASK
      && st_reg.fbval == `RST_FB_VALUE && st_reg.p2mode == `RST_PIN2_MODE)
    else $error("configuration reset values wrong");

  // Register port and image checks: words 2, 3 and 5 read back are rebuilt
  // here from the synced pins and the configuration seen at the read
  rd_idle_a: assert property (
    !rd_en_i |=> rd_data_o == 16'h0000)
    else $error("read data present without a read");

  common_word_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 + 4'h2 |=>
      rd_data_o == $past(cdiag_s))
    else $error("common diagnostic word wrong");

  sens_word_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 + 4'h3 |=>
      rd_data_o == {8'h00, $past(sshort_s) & $past(st_reg.p2mode)})
    else $error("sensor supply word wrong");

  act_word_a: assert property (
    rd_en_i && addr_i == `OFS_WORD5 |=>
      rd_data_o == {8'h00, $past(awarn_s) & $past(st_reg.dir)
                    & $past(st_reg.p2mode)})
    else $error("actuator warning word wrong");

  word_end_a: assert property (
    rd_en_i && addr_i > `OFS_WORD5 && addr_i != `OFS_OUT_STATE |=>
      rd_data_o == 16'h0000)
    else $error("read past the six words not zero");

  diag_mask_a: assert property (
    rd_en_i && addr_i == `OFS_WORD0 + 4'h1 |=>
      (rd_data_o[7:0] & $past(st_reg.inmask)) == 8'h00)
    else $error("masked pin-2 bit reported");

  // Mode checks: stop outranks fallback, fallback outranks run
  ctrl_mode_a: assert property (
    rd_en_i && addr_i == `OFS_CTRL |=>
      rd_data_o[2] == $past(stop_o) && rd_data_o[1] == $past(fallback_o))
    else $error("control read does not show the mode");

  run_mode_a: assert property (
    !fb_now && !hold_now |=> !fallback_o && !stop_o)
    else $error("fallback or stop shown in normal run");

  stop_first_a: assert property (
    hold_now |=> !fallback_o)
    else $error("fallback shown while stop holds");

  loss_fall_a: assert property (
    link_loss && !hold_now |=> fallback_o)
    else $error("loss event did not give fallback");

  fall_seen_c: cover property ($rose(fallback_o));
  stop_seen_c: cover property ($rose(stop_o) ##[1:20] !stop_o);
  word_read_c: cover property (rd_en_i && addr_i == `OFS_WORD5);
  resume_c: cover property (fallback_o ##1 !fallback_o);
  loss_in_stop_c: cover property (hold_now && link_loss);
endmodule // splitter_channel_io

// >>> testbench/iface_model.sv
// Far-side model: island interface module loss levels and placement.
// Assumes the bench changes lose_i by non-blocking assignment on
// ref_clk_i, so every indication is synchronous to the block's clock.
`timescale 1ns/1ps
module iface_model (
  input wire logic [3:0] lose_i,
  output logic comm_lost_o,
  output logic iface_fail_o,
  output logic bus_cable_lost_o,
  output logic ext_cable_lost_o,
  output logic [15:0] img_first_o
);
  // Node address of the box on the island; any legal address will do
  localparam int NODE = 5;
  // Plain levels, no latching: each loss lasts as long as it is requested
  assign comm_lost_o = lose_i[0];
  assign iface_fail_o = lose_i[1];
  assign bus_cable_lost_o = lose_i[2];
  assign ext_cable_lost_o = lose_i[3];
  // Six words per node, packed from the start of the reserved image
  assign img_first_o = 16'hb150 + 16'(6 * (NODE - 1));
endmodule // iface_model

// >>> testbench/tb.sv
// Self-checking bench for splitter_channel_io over its register port.
// Assumes the far-side loss levels come from iface_model.
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data, r, img_first;
  logic [3:0] lose = 4'h0;
  logic comm_lost, iface_fail, bus_lost, ext_lost, fb_out, stop_out;
  logic [7:0] pin4_in = 8'ha5, pin2_in = 8'h3c;
  logic [15:0] cdiag = 16'h1234;
  logic [7:0] s_short = 8'hff, a_short = 8'hff, a_warn = 8'h55;
  logic [7:0] p4_out, p4_oe_n;
  logic [7:0] rst_tab [6] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
  logic [15:0] img [6] = '{16'h0020, 16'h0032, 16'h1234, 16'h000f,
                           16'h000f, 16'h0005};
  int miscompares = 0, n_checks = 0, cycles = 0;

  initial forever #20 ref_clk_i = ~ref_clk_i;

  iface_model far (.lose_i(lose), .comm_lost_o(comm_lost),
    .iface_fail_o(iface_fail), .bus_cable_lost_o(bus_lost),
    .ext_cable_lost_o(ext_lost), .img_first_o(img_first));

  splitter_channel_io uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .rd_data_o(rd_data), .comm_lost_i(comm_lost), .iface_fail_i(iface_fail),
    .bus_cable_lost_i(bus_lost), .ext_cable_lost_i(ext_lost),
    .pin4_i(pin4_in), .pin4_o(p4_out), .pin4_oe_n_o(p4_oe_n),
    .pin2_i(pin2_in), .common_diag_i(cdiag), .sensor_short_i(s_short),
    .act_short_i(a_short), .act_warn_i(a_warn), .fallback_o(fb_out),
    .stop_o(stop_out));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr_en <= 1'b0;
    #1;
  endtask

  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // Loss level changes at one edge; outputs are judged after the next
  task lose_set(input logic [3:0] v, input logic fb_was);
    @(posedge ref_clk_i);
    lose <= v;
    #1;
    chk({15'h0000, fb_out}, {15'h0000, fb_was});
    @(posedge ref_clk_i);
    #1;
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is about 140 cycles; ceiling leaves a wide margin
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    chk({8'h00, p4_oe_n}, 16'h00ff);
    chk({8'h00, p4_out}, 16'h0000);
    chk({15'h0000, img_first >= 16'hb150 && img_first <= 16'hc14a},
        16'h0001);
    for (int i = 0; i < 6; i++) begin
      rd(i[3:0], r);
      chk(r, {8'h00, rst_tab[i]});
    end
    wr(4'h0, 16'h000f);
    chk({8'h00, p4_oe_n}, 16'h00f0);
    rd(4'h8, r);
    chk(r, 16'h00a0);
    rd(4'h9, r);
    chk(r, 16'h00c3);
    wr(4'h2, 16'h0081);
    wr(4'h1, 16'h000f);
    wr(4'h9, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      rd(4'h8 + i[3:0], r);
      chk(r, img[i]);
    end
    rd(4'hf, r);
    chk(r, 16'h0000);
    @(posedge ref_clk_i);
    #1 chk(rd_data, 16'h0000);
    wr(4'h6, 16'h000a);
    @(posedge ref_clk_i);
    #1 chk({8'h00, p4_out}, 16'h000a);
    wr(4'h5, 16'h00f0);
    wr(4'h6, 16'h0005);
    @(posedge ref_clk_i);
    #1 chk({8'h00, p4_out}, 16'h000a);
    wr(4'h5, 16'h00ff);
    wr(4'h3, 16'h0003);
    wr(4'h4, 16'h0001);
    wr(4'h6, 16'h000a);
    @(posedge ref_clk_i);
    lose_set(4'h1, 1'b0);
    chk({8'h00, p4_out}, 16'h0009);
    wr(4'h6, 16'h0006);
    repeat (3) @(posedge ref_clk_i);
    #1 chk({8'h00, p4_out}, 16'h0009);
    lose_set(4'h0, 1'b1);
    chk({8'h00, p4_out}, 16'h0006);
    for (int k = 1; k < 4; k++) begin
      lose_set(4'h1 << k, 1'b0);
      chk({8'h00, p4_out}, 16'h0005);
      lose_set(4'h0, 1'b1);
    end
    for (int k = 0; k < 3; k++) begin
      wr(4'h7, 16'h0001 << k);
      chk({15'h0000, fb_out}, 16'h0001);
      chk({8'h00, p4_out}, 16'h0005);
      rd(4'h7, r);
      chk(r, 16'h0002);
      wr(4'h7, 16'h0010);
      rd(4'h7, r);
      chk(r, 16'h0001);
      chk({8'h00, p4_out}, 16'h0006);
    end
    wr(4'h7, 16'h0008);
    chk({15'h0000, stop_out}, 16'h0001);
    wr(4'h6, 16'h0009);
    @(posedge ref_clk_i);
    #1 chk({8'h00, p4_out}, 16'h0006);
    @(posedge ref_clk_i);
    lose <= 4'h1;
    repeat (2) @(posedge ref_clk_i);
    #1 chk({8'h00, p4_out}, 16'h0006);
    rd(4'h7, r);
    chk(r, 16'h0004);
    lose_set(4'h0, 1'b0);
    wr(4'h7, 16'h0010);
    @(posedge ref_clk_i);
    #1 chk({15'h0000, stop_out}, 16'h0000);
    chk({8'h00, p4_out}, 16'h0009);
    rd(4'he, r);
    chk(r, 16'h0009);
    give_verdict();
  end
endmodule // tb
